//--- hdl/sfp_fifo.sv
// flip-flop fifo with valid/ready on both sides and a flush
`timescale 1ns/1ps
module sfp_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 32
) (
    input logic mclk,
    input logic sys_rst,
    input logic flush,
    input logic inValid,
    output logic inReady,
    input logic [W-1:0] inData,
    output logic outValid,
    input logic outReady,
    output logic [W-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [W-1:0] mem_d [DEPTH];
    logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    assign inReady = cnt_q != FULL_CNT;
    assign outValid = cnt_q != '0;
    assign outData = mem_q[rdPtr_q];

    always_comb begin
        mem_d = mem_q;
        push = inValid & inReady;
        pop = outValid & outReady;
        wrPtr_d = wrPtr_q;
        rdPtr_d = rdPtr_q;
        cnt_d = cnt_q;
        if (flush) begin
            wrPtr_d = '0;
            rdPtr_d = '0;
            cnt_d = '0;
        end else begin
            if (push) begin
                mem_d[wrPtr_q] = inData;
                wrPtr_d = wrPtr_q + AW'(1);
            end
            if (pop) begin
                rdPtr_d = rdPtr_q + AW'(1);
            end
            cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            cnt_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            cnt_q <= cnt_d;
        end
        mem_q <= mem_d;
    end
endmodule

//--- hdl/sfp_flash_ctrl.sv
// serial flash command block: protection, reads and erases behind the serial pins
`timescale 1ns/1ps
module sfp_flash_ctrl #(
    parameter int unsigned SECTOR_ERASE_CYC = sfp_pkg::SECTOR_ERASE_TIME_US * sfp_pkg::MCLK_MHZ,
    parameter int unsigned BLOCK_ERASE_CYC = sfp_pkg::BLOCK_ERASE_TIME_US * sfp_pkg::MCLK_MHZ,
    parameter int unsigned CHIP_ERASE_CYC = sfp_pkg::CHIP_ERASE_TIME_US * sfp_pkg::MCLK_MHZ,
    parameter int unsigned DUAL_DUMMY_CLKS = sfp_pkg::DUAL_DUMMY_DEFAULT
) (
    input logic mclk,
    input logic sys_rst,
    input logic csN,
    input logic sclk,
    input logic siIn,
    output logic siOut,
    output logic siOe,
    output logic soOut,
    output logic soOe,
    input logic wpN,
    output logic arrayRdEn,
    output logic [sfp_pkg::ARRAY_AW-1:0] arrayAddr,
    input logic [sfp_pkg::BYTE_W-1:0] arrayRdData,
    output logic eraseStart,
    output sfp_pkg::sfp_erase_t eraseReq,
    output sfp_pkg::sfp_status_t status,
    output logic hwProtectedMode
);
    import sfp_pkg::*;

    localparam logic [5:0] FAST_START = ADDR_END + FAST_DUMMY_BITS;
    localparam logic [5:0] DUAL_START = ADDR_END + 6'(DUAL_DUMMY_CLKS);

    // ==========================================================
    // decoding helpers
    function automatic logic isProtected(input logic [ARRAY_AW-1:0] a, input logic [1:0] lvl);
        case (lvl)
            2'h1: isProtected = &a[ARRAY_AW-1 -: 2];
            2'h2: isProtected = a[ARRAY_AW-1];
            2'h3: isProtected = 1'b1;
            default: isProtected = 1'b0;
        endcase
    endfunction

    // frame bit count at which data output starts, zero for non-reads
    function automatic logic [5:0] dataStart(input logic [7:0] opc);
        case (opc)
            OP_READ: dataStart = ADDR_END;
            OP_FAST_READ: dataStart = FAST_START;
            OP_DUAL_OUTPUT_READ: dataStart = DUAL_START;
            default: dataStart = 6'h00;
        endcase
    endfunction

    function automatic sfp_state_t afterOpcode(input logic [7:0] opc, input logic busy);
        if (busy) begin
            // only the status read is served during a cycle
            afterOpcode = (opc == OP_STATUS_READ) ? S_STAT : S_IGN;
        end else begin
            case (opc)
                OP_STATUS_READ: afterOpcode = S_STAT;
                OP_READ, OP_FAST_READ, OP_DUAL_OUTPUT_READ,
                OP_SET_WRITE_LATCH, OP_CLR_WRITE_LATCH, OP_STATUS_WRITE,
                OP_SECTOR_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE: afterOpcode = S_ADDR;
                default: afterOpcode = S_IGN;
            endcase
        end
    endfunction

    // ==========================================================
    // pins and edges
    logic [3:0] pinsF;
    logic csF, sclkF, siF, wpF;
    logic sclkPrev_q, sclkPrev_d, csPrev_q, csPrev_d;
    logic sclkRise, sclkFall, csRise;

    sfp_sync #(
        .W(4),
        .RST_VAL(PIN_IDLE)
    ) u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din({csN, sclk, siIn, wpN}),
        .dout(pinsF)
    );

    assign csF = pinsF[3];
    assign sclkF = pinsF[2];
    assign siF = pinsF[1];
    assign wpF = pinsF[0];

    always_comb begin
        sclkPrev_d = sclkF;
        csPrev_d = csF;
        sclkRise = sclkF & ~sclkPrev_q & ~csF;
        sclkFall = ~sclkF & sclkPrev_q & ~csF;
        csRise = csF & ~csPrev_q;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sclkPrev_q <= 1'b0;
            csPrev_q <= 1'b1;
        end else begin
            sclkPrev_q <= sclkPrev_d;
            csPrev_q <= csPrev_d;
        end
    end

    // ==========================================================
    // frame decoder
    sfp_state_t state_q, state_d;
    logic [5:0] bitCnt_q, bitCnt_d;
    logic [ADDR_W-1:0] sh_q, sh_d;
    logic [7:0] opc_q, opc_d;
    logic enterOut;
    sfp_status_t status_q, status_d;

    always_comb begin
        state_d = state_q;
        bitCnt_d = bitCnt_q;
        sh_d = sh_q;
        opc_d = opc_q;
        enterOut = 1'b0;
        if (csF) begin
            // deselect ends any frame at any bit, reads included
            state_d = S_OPC;
            bitCnt_d = 6'h00;
        end else if (sclkRise) begin
            if (bitCnt_q != BIT_CNT_MAX) begin
                bitCnt_d = bitCnt_q + 6'h01;
            end
            // shifting stops after the address so dummy bits leave it intact
            if (bitCnt_q < ADDR_END) begin
                sh_d = {sh_q[ADDR_W-2:0], siF};
            end
            case (state_q)
                S_OPC: begin
                    if (bitCnt_q == OPC_BITS - 6'h01) begin
                        opc_d = {sh_q[6:0], siF};
                        state_d = afterOpcode(opc_d, status_q.writeInProgress);
                    end
                end
                S_ADDR: begin
                    if (bitCnt_d == dataStart(opc_q)) begin
                        state_d = S_OUT;
                        enterOut = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q <= S_OPC;
            bitCnt_q <= 6'h00;
            sh_q <= '0;
            opc_q <= 8'h00;
        end else begin
            state_q <= state_d;
            bitCnt_q <= bitCnt_d;
            sh_q <= sh_d;
            opc_q <= opc_d;
        end
    end

    // ==========================================================
    // status register, write latch and self-timed cycles
    logic [31:0] busyCnt_q, busyCnt_d;
    logic stwPend_q, stwPend_d;
    sfp_status_t stwData_q, stwData_d;
    logic eraseStart_q, eraseStart_d;
    sfp_erase_t eraseReq_q, eraseReq_d;
    logic hwMode_q, hwMode_d;
    logic hwNow, latchOk;
    logic [ARRAY_AW-1:0] secBase, blkBase;

    always_comb begin
        status_d = status_q;
        busyCnt_d = busyCnt_q;
        stwPend_d = stwPend_q;
        stwData_d = stwData_q;
        eraseStart_d = 1'b0;
        eraseReq_d = eraseReq_q;
        hwNow = status_q.statusWriteDisable & ~wpF;
        hwMode_d = hwNow;
        latchOk = status_q.writeEnableLatch;
        secBase = sh_q[ARRAY_AW-1:0] & SECTOR_MASK;
        blkBase = sh_q[ARRAY_AW-1:0] & BLOCK_MASK;
        if (status_q.writeInProgress) begin
            busyCnt_d = busyCnt_q - 32'h1;
            if (busyCnt_q == 32'h1) begin
                status_d.writeInProgress = 1'b0;
                status_d.writeEnableLatch = 1'b0;
                if (stwPend_q) begin
                    status_d.statusWriteDisable = stwData_q.statusWriteDisable;
                    status_d.protectLevel = stwData_q.protectLevel;
                end
                stwPend_d = 1'b0;
            end
        end else if (csRise && state_q == S_ADDR) begin
            case (opc_q)
                OP_SET_WRITE_LATCH: begin
                    if (bitCnt_q == OPC_BITS) begin
                        status_d.writeEnableLatch = 1'b1;
                    end
                end
                OP_CLR_WRITE_LATCH: begin
                    if (bitCnt_q == OPC_BITS) begin
                        status_d.writeEnableLatch = 1'b0;
                    end
                end
                OP_STATUS_WRITE: begin
                    // protect pin only matters once the disable bit is set
                    if (bitCnt_q == STW_BITS && latchOk && !hwNow) begin
                        status_d.writeInProgress = 1'b1;
                        busyCnt_d = 32'(STW_CYC);
                        stwPend_d = 1'b1;
                        stwData_d = sh_q[7:0];
                    end
                end
                OP_SECTOR_ERASE: begin
                    if (bitCnt_q == ADDR_END && latchOk
                            && !isProtected(secBase, status_q.protectLevel)) begin
                        status_d.writeInProgress = 1'b1;
                        busyCnt_d = 32'(SECTOR_ERASE_CYC);
                        eraseStart_d = 1'b1;
                        eraseReq_d = '{kind: ER_SECTOR, base: secBase};
                    end
                end
                OP_BLOCK_ERASE: begin
                    if (bitCnt_q == ADDR_END && latchOk
                            && !isProtected(blkBase, status_q.protectLevel)) begin
                        status_d.writeInProgress = 1'b1;
                        busyCnt_d = 32'(BLOCK_ERASE_CYC);
                        eraseStart_d = 1'b1;
                        eraseReq_d = '{kind: ER_BLOCK, base: blkBase};
                    end
                end
                OP_CHIP_ERASE: begin
                    if (bitCnt_q == OPC_BITS && latchOk && status_q.protectLevel == 2'h0) begin
                        status_d.writeInProgress = 1'b1;
                        busyCnt_d = 32'(CHIP_ERASE_CYC);
                        eraseStart_d = 1'b1;
                        eraseReq_d = '{kind: ER_CHIP, base: '0};
                    end
                end
                default: begin
                end
            endcase
        end
        status_d.rsvd = 3'h0;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            status_q <= STATUS_RST;
            busyCnt_q <= 32'h0;
            stwPend_q <= 1'b0;
            stwData_q <= STATUS_RST;
            eraseStart_q <= 1'b0;
            eraseReq_q <= '0;
            hwMode_q <= 1'b0;
        end else begin
            status_q <= status_d;
            busyCnt_q <= busyCnt_d;
            stwPend_q <= stwPend_d;
            stwData_q <= stwData_d;
            eraseStart_q <= eraseStart_d;
            eraseReq_q <= eraseReq_d;
            hwMode_q <= hwMode_d;
        end
    end

    // ==========================================================
    // array fetch into the read fifo
    logic arrayRdEn_q, arrayRdEn_d;
    logic [ARRAY_AW-1:0] arrayAddr_q, arrayAddr_d;
    logic rdDly_q, rdDly_d;
    logic fifoInReady, fifoOutValid, fifoPop;
    logic [BYTE_W-1:0] fifoOutData;

    // one read in flight keeps the fifo count honest without a credit counter
    always_comb begin
        arrayRdEn_d = 1'b0;
        arrayAddr_d = arrayAddr_q;
        rdDly_d = arrayRdEn_q;
        if (enterOut) begin
            arrayRdEn_d = 1'b1;
            arrayAddr_d = sh_d[ARRAY_AW-1:0];
        end else if (state_q == S_OUT && !csF && !arrayRdEn_q && !rdDly_q && fifoInReady) begin
            arrayRdEn_d = 1'b1;
            arrayAddr_d = arrayAddr_q + ARRAY_AW'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            arrayRdEn_q <= 1'b0;
            arrayAddr_q <= '0;
            rdDly_q <= 1'b0;
        end else begin
            arrayRdEn_q <= arrayRdEn_d;
            arrayAddr_q <= arrayAddr_d;
            rdDly_q <= rdDly_d;
        end
    end

    sfp_fifo #(
        .W(BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .flush(csF),
        .inValid(rdDly_q),
        .inReady(fifoInReady),
        .inData(arrayRdData),
        .outValid(fifoOutValid),
        .outReady(fifoPop),
        .outData(fifoOutData)
    );

    // ==========================================================
    // output shifter
    logic [7:0] outSh_q, outSh_d;
    logic [2:0] outCnt_q, outCnt_d;
    logic soOut_q, soOut_d, soOe_q, soOe_d;
    logic siOut_q, siOut_d, siOe_q, siOe_d;
    logic dual, outActive;
    logic [7:0] curByte;

    always_comb begin
        outSh_d = outSh_q;
        outCnt_d = outCnt_q;
        soOut_d = soOut_q;
        siOut_d = siOut_q;
        fifoPop = 1'b0;
        outActive = state_q == S_OUT || state_q == S_STAT;
        dual = state_q == S_OUT && opc_q == OP_DUAL_OUTPUT_READ;
        curByte = outSh_q;
        if (outCnt_q == 3'h0) begin
            // an empty fifo here means the serial clock outran the array; zeros go out
            curByte = (state_q == S_STAT) ? status_q : (fifoOutValid ? fifoOutData : 8'h00);
        end
        if (csF) begin
            outCnt_d = 3'h0;
        end else if (sclkFall && outActive) begin
            fifoPop = state_q == S_OUT && outCnt_q == 3'h0 && fifoOutValid;
            soOut_d = curByte[7];
            if (dual) begin
                siOut_d = curByte[6];
                outSh_d = {curByte[5:0], 2'h0};
                outCnt_d = outCnt_q + 3'h2;
            end else begin
                outSh_d = {curByte[6:0], 1'b0};
                outCnt_d = outCnt_q + 3'h1;
            end
        end
        soOe_d = ~csF & outActive;
        siOe_d = ~csF & dual;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            outSh_q <= 8'h00;
            outCnt_q <= 3'h0;
            soOut_q <= 1'b0;
            soOe_q <= 1'b0;
            siOut_q <= 1'b0;
            siOe_q <= 1'b0;
        end else begin
            outSh_q <= outSh_d;
            outCnt_q <= outCnt_d;
            soOut_q <= soOut_d;
            soOe_q <= soOe_d;
            siOut_q <= siOut_d;
            siOe_q <= siOe_d;
        end
    end

    // ==========================================================
    // outputs
    assign soOut = soOut_q;
    assign soOe = soOe_q;
    assign siOut = siOut_q;
    assign siOe = siOe_q;
    assign arrayRdEn = arrayRdEn_q;
    assign arrayAddr = arrayAddr_q;
    assign eraseStart = eraseStart_q;
    assign eraseReq = eraseReq_q;
    assign status = status_q;
    assign hwProtectedMode = hwMode_q;
endmodule

//--- hdl/sfp_pkg.sv
// shared constants, opcodes, timing and types of the serial flash command block
package sfp_pkg;
    // ==========================================================
    // array geometry
    localparam int ADDR_W = 24;
    localparam int ARRAY_AW = 20;
    localparam int SECTOR_LSB = 12;
    localparam int BLOCK_LSB = 16;
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 32;
    localparam logic [ARRAY_AW-1:0] SECTOR_MASK = ARRAY_AW'(~((1 << SECTOR_LSB) - 1));
    localparam logic [ARRAY_AW-1:0] BLOCK_MASK = ARRAY_AW'(~((1 << BLOCK_LSB) - 1));

    // ==========================================================
    // frame bit counts, counted in rising serial clock edges
    localparam logic [5:0] OPC_BITS = 6'h08;
    localparam logic [5:0] STW_BITS = 6'h10;
    localparam logic [5:0] ADDR_END = 6'h20;
    localparam logic [5:0] FAST_DUMMY_BITS = 6'h08;
    localparam logic [5:0] BIT_CNT_MAX = 6'h3f;

    // ==========================================================
    // opcodes, values are arbitrary and may be edited freely
    localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h11;
    localparam logic [7:0] OP_CLR_WRITE_LATCH = 8'h12;
    localparam logic [7:0] OP_STATUS_READ = 8'h13;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h14;
    localparam logic [7:0] OP_READ = 8'h15;
    localparam logic [7:0] OP_FAST_READ = 8'h16;
    localparam logic [7:0] OP_DUAL_OUTPUT_READ = 8'h17;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h18;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'h19;
    localparam logic [7:0] OP_CHIP_ERASE = 8'h1a;

    // ==========================================================
    // timing
    localparam int MCLK_MHZ = 40;
    localparam int STW_TIME_US = 10;
    localparam int SECTOR_ERASE_TIME_US = 100;
    localparam int BLOCK_ERASE_TIME_US = 500;
    localparam int CHIP_ERASE_TIME_US = 4000;
    localparam int STW_CYC = STW_TIME_US * MCLK_MHZ;
    localparam int DUAL_DUMMY_DEFAULT = 8;

    // ==========================================================
    // pin order {csN, sclk, siIn, wpN} and idle levels
    localparam logic [3:0] PIN_IDLE = 4'h9;

    // ==========================================================
    // types
    typedef struct packed {
        logic statusWriteDisable;
        logic [2:0] rsvd;
        logic [1:0] protectLevel;
        logic writeEnableLatch;
        logic writeInProgress;
    } sfp_status_t;
    localparam sfp_status_t STATUS_RST = 8'h00;

    typedef enum logic [1:0] {
        ER_SECTOR = 2'h0,
        ER_BLOCK = 2'h1,
        ER_CHIP = 2'h2
    } sfp_erase_kind_t;

    typedef struct packed {
        sfp_erase_kind_t kind;
        logic [ARRAY_AW-1:0] base;
    } sfp_erase_t;

    typedef enum logic [4:0] {
        S_OPC = 5'h01,
        S_ADDR = 5'h02,
        S_OUT = 5'h04,
        S_STAT = 5'h08,
        S_IGN = 5'h10
    } sfp_state_t;
endpackage

//--- hdl/sfp_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module sfp_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input logic mclk,
    input logic sys_rst,
    input logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_q, s2_q, s3_q, f_q, f_d;
    logic [W-1:0] agree;

    // a bit changes only once stages two and three agree
    always_comb begin
        agree = ~(s2_q ^ s3_q);
        f_d = (agree & s3_q) | (~agree & f_q);
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            f_q <= RST_VAL;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            f_q <= f_d;
        end
    end

    assign dout = f_q;
endmodule

//--- sim/sfp_flash_props.sv
// port assertions of the flash command block
`timescale 1ns/1ps
module sfp_flash_props (
    input logic mclk,
    input logic sys_rst,
    input logic siOe,
    input logic arrayRdEn,
    input logic eraseStart,
    input sfp_pkg::sfp_erase_t eraseReq,
    input sfp_pkg::sfp_status_t status,
    input logic hwProtectedMode
);
    import sfp_pkg::*;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    sequence s_launch;
        status.writeInProgress ##1 !eraseStart;
    endsequence
    a_dual_pair: assert property (siOe |-> status.writeInProgress == 1'b0)
        else $error("dual data while busy");
    a_hw_mode: assert property (hwProtectedMode |->
        $past(status.statusWriteDisable)) else $error("hw mode without disable");
    a_erase_busy: assert property (eraseStart |-> s_launch)
        else $error("erase launch");
    a_chip_level: assert property (eraseStart && eraseReq.kind == ER_CHIP
        |-> status.protectLevel == 2'h0) else $error("chip erase protected");
    a_sect_align: assert property (eraseStart && eraseReq.kind == ER_SECTOR
        |-> eraseReq.base[11:0] == 12'h0) else $error("sector base");
    a_busy_end: assert property ($fell(status.writeInProgress)
        |-> !status.writeEnableLatch) else $error("latch kept");
    a_busy_quiet: assert property (status.writeInProgress |-> !arrayRdEn)
        else $error("array read while busy");
    a_busy_hold: assert property ($rose(status.writeInProgress)
        |-> status.writeInProgress [*8]) else $error("busy too short");
endmodule

//--- sim/sfp_host.sv
// serial host model: drives frames and samples the returned bits
`timescale 1ns/1ps
module sfp_host (
    output logic csN,
    output logic sclk,
    output logic si,
    input wire logic so,
    input wire logic si2
);
    // idle clock level; high selects the idle-high clock mode
    logic cpol = 1'b0;
    initial {csN, sclk, si} = 3'h4;
    // sampling a full period after each fall leaves room for the sync delay
    task automatic xfer(input logic [39:0] d, input int nb, input int nr, input logic dl,
        output logic [15:0] q);
        q = 16'h0;
        csN = 1'b0;
        if (cpol) #100 sclk = 1'b0;
        for (int i = 0; i < nb; i++) begin
            si = d[39-i];
            #100 sclk = 1'b1;
            #100 sclk = 1'b0;
        end
        si = ~si;
        for (int i = 0; i < nr; i++) begin
            #100 sclk = 1'b1;
            #100 q = dl ? {q[13:0], so, si2} : {q[14:0], so};
            sclk = 1'b0;
        end
        #100 sclk = cpol;
        #100 csN = 1'b1;
        #300;
    endtask
endmodule

//--- sim/tb_top.sv
// self-checking bench of the flash command block
`timescale 1ns/1ps
module tb_top;
    import sfp_pkg::*;
    logic mclk, sys_rst, wpN, csN, sclk, hostSi, siIn, siOut, siOe, soOut, soOe;
    logic arrayRdEn, eraseStart, hwProtectedMode;
    logic oeSeen = 1'b0;
    logic [ARRAY_AW-1:0] arrayAddr;
    logic [7:0] arrayRdData = 8'h00;
    sfp_erase_t eraseReq;
    sfp_status_t status;
    logic [15:0] q;
    int n_errors = 0;
    int num_checks = 0;
    assign siIn = siOe ? siOut : hostSi;
    sfp_host host_u (.csN(csN), .sclk(sclk), .si(hostSi), .so(soOut), .si2(siIn));
    sfp_flash_ctrl #(.SECTOR_ERASE_CYC(600), .BLOCK_ERASE_CYC(700), .CHIP_ERASE_CYC(800))
        dut_u (.*);
    function automatic logic [7:0] pat(input logic [19:0] a);
        return a[7:0] ^ a[19:12] ^ 8'h5a;
    endfunction
    // data churns between requests so a late sample cannot pass
    always @(posedge mclk) begin
        arrayRdData <= arrayRdEn ? pat(arrayAddr) : ~arrayRdData;
        oeSeen <= oeSeen | soOe;
    end
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic chk(input string nm, input logic [21:0] e, input logic [21:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic op(input logic [7:0] c, input logic [23:0] a, input int nb, input int nr,
        input logic dl = 1'b0);
        @(posedge mclk) #1 host_u.xfer({c, a, 8'h00}, nb, nr, dl, q);
    endtask
    task automatic wbusy(input logic v);
        int k;
        for (k = 0; k < 2000 && status.writeInProgress !== v; k++) @(posedge mclk) #1;
        if (k == 2000) begin
            n_errors++;
            final_report();
        end
    endtask
    initial begin
        sys_rst = 1'b1;
        wpN = 1'b1;
        repeat (2) @(posedge mclk);
        #1 sys_rst = 1'b0;
        repeat (8) @(posedge mclk);
        chk("status", 8'h00, status);
        op(OP_READ, 24'hffffff, 32, 16);
        chk("wrap", {pat(20'hfffff), pat(20'h0)}, q);
        op(OP_FAST_READ, 24'h012345, 40, 8);
        chk("fast", pat(20'h12345), q);
        op(OP_DUAL_OUTPUT_READ, 24'h000010, 40, 8, 1'b1);
        chk("dual", {pat(20'h10), pat(20'h11)}, q);
        op(OP_SECTOR_ERASE, 24'h012345, 32, 0);
        chk("no latch", 8'h00, status);
        op(OP_SET_WRITE_LATCH, 0, 8, 0);
        op(OP_STATUS_READ, 0, 8, 8);
        chk("st read", 8'h02, q);
        host_u.cpol = 1'b1;
        host_u.sclk = 1'b1;
        repeat (8) @(posedge mclk);
        op(OP_STATUS_READ, 0, 8, 8);
        chk("st mode3", 8'h02, q);
        host_u.cpol = 1'b0;
        host_u.sclk = 1'b0;
        repeat (8) @(posedge mclk);
        op(OP_SECTOR_ERASE, 24'h012345, 31, 0);
        chk("short", 8'h02, status);
        op(OP_SECTOR_ERASE, 24'h012345, 32, 0);
        chk("busy", 8'h03, status);
        chk("sector", {ER_SECTOR, 20'h12000}, eraseReq);
        oeSeen = 1'b0;
        op(OP_DUAL_OUTPUT_READ, 0, 40, 4, 1'b1);
        chk("refused", 1'b0, oeSeen);
        wbusy(0);
        chk("done", 8'h00, status);
        op(OP_SET_WRITE_LATCH, 0, 8, 0);
        op(OP_STATUS_WRITE, 24'h8c0000, 16, 0);
        wbusy(0);
        chk("sw", 8'h8c, status);
        op(OP_SET_WRITE_LATCH, 0, 8, 0);
        op(OP_BLOCK_ERASE, 24'h0f0000, 32, 0);
        op(OP_CHIP_ERASE, 0, 8, 0);
        chk("protect", 8'h8c, status & 8'h8d);
        @(posedge mclk) #1 wpN = 1'b0;
        repeat (8) @(posedge mclk);
        chk("hw on", 1'b1, hwProtectedMode);
        op(OP_SET_WRITE_LATCH, 0, 8, 0);
        op(OP_STATUS_WRITE, 24'h000000, 16, 0);
        chk("hw keep", 8'h8c, status & 8'h8d);
        @(posedge mclk) #1 wpN = 1'b1;
        repeat (8) @(posedge mclk);
        chk("hw off", 1'b0, hwProtectedMode);
        op(OP_SET_WRITE_LATCH, 0, 8, 0);
        op(OP_STATUS_WRITE, 24'h000000, 16, 0);
        wbusy(0);
        chk("unlock", 8'h00, status);
        op(OP_SET_WRITE_LATCH, 0, 8, 0);
        op(OP_CHIP_ERASE, 0, 8, 0);
        chk("chip", ER_CHIP, eraseReq.kind);
        wbusy(0);
        chk("chip end", 8'h00, status);
        final_report();
    end
endmodule
bind sfp_flash_ctrl sfp_flash_props props_u (.*);
